// ---- hdl/store_exec_cfg.svh ----
// Purpose: Offsets, field positions, reset values and opcode patterns of the store executor
// Assumes: Byte offsets on a 32-bit AHB-Lite data bus, one register per aligned word
// Notes:   Definitions only
`ifndef STORE_EXEC_CFG_SVH
`define STORE_EXEC_CFG_SVH

// ****************************************
// Register word indices (byte address = index * 4)
// ****************************************
`define IDX_CTRL        6'h00
`define IDX_INSN        6'h01
`define IDX_OPER_FIRST  6'h02
`define IDX_OPER_LAST   6'h0B
`define IDX_SUM_OVF     6'h0C
`define IDX_RESV_CMD    6'h0D
`define IDX_STATUS      6'h0E
`define IDX_EA_LO       6'h0F
`define IDX_EA_HI       6'h10
`define OPER_WORDS      10

// ****************************************
// Field positions
// ****************************************
`define ST_ILLEGAL      0
`define ST_BAD_FORM     1
`define ST_ALIGN        2
`define ST_PERFORMED    3
`define ST_RESV_VALID   4
`define ST_CR0_LSB      8
`define CR0_LESS        3
`define CR0_GREATER     2
`define CR0_EQUAL       1
`define CR0_SUM_OVF     0

// ****************************************
// Opcode patterns and masks
// ****************************************
`define MASK_X          32'hFC00_07FF
`define MASK_DS         32'hFC00_0003
`define MASK_D          32'hFC00_0000
`define PAT_BYTE_UX     32'h7C00_01EE
`define PAT_BYTE_X      32'h7C00_01AE
`define PAT_DW          32'hF800_0000
`define PAT_DW_COND     32'h7C00_01AD
`define PAT_DW_U        32'hF800_0001
`define PAT_DW_UX       32'h7C00_016A
`define PAT_DW_X        32'h7C00_012A
`define PAT_FD          32'hD800_0000
`define PAT_FD_U        32'hDC00_0000

// ****************************************
// Store size codes and reset values
// ****************************************
`define SIZE_BYTE       2'h0
`define SIZE_DWORD      2'h3
`define RST_WORD        32'h0000_0000
`define RST_ADDR        64'h0000_0000_0000_0000

`endif

// ---- hdl/store_exec_pkg.sv ----
// Purpose: Types shared by the store executor
// Assumes: Nothing beyond SystemVerilog
// Notes:   Numbers live in store_exec_cfg.svh
package store_exec_pkg;

  // Decoded store kinds
  typedef enum logic [3:0] {
    OP_NONE,
    OP_BYTE_UX,
    OP_BYTE_X,
    OP_DW,
    OP_DW_U,
    OP_DW_COND,
    OP_DW_UX,
    OP_DW_X,
    OP_FD,
    OP_FD_U
  } op_t;

endpackage

// ---- hdl/store_insn_exec_reservation.sv ----
// Purpose: Executes byte, doubleword and float-double stores and keeps the reservation
// Assumes: AHB-Lite slave, single word transfers, clk_sys at 200 MHz, no wait states
// Notes:   Writing the instruction word starts execution; results show one edge later
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "store_exec_cfg.svh"

module store_insn_exec_reservation #(
  parameter bit IMPL_64 = 1'b1,
  parameter int XLEN    = 64
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             memWrite,
  output logic      [63:0] memAddr,
  output logic      [63:0] memData,
  output logic      [1:0]  memSize,
  output logic             resvHeld,
  input  wire logic        snoopValid,
  input  wire logic [63:0] snoopAddr
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // Datapath is written for 64-bit registers only
  if (XLEN != 64) begin : g_bad_xlen
    $error("XLEN must be 64");
  end

  // ****************************************
  // Functions
  // ****************************************
  // Masked opcode compare, used for every pattern
  function automatic logic isMatch(logic [31:0] w, logic [31:0] m, logic [31:0] p);
    return (w & m) == p;
  endfunction

  // Opcode to store kind
  function automatic store_exec_pkg::op_t decodeOp(logic [31:0] w);
    store_exec_pkg::op_t k;
    k = store_exec_pkg::OP_NONE;
    if (isMatch(w, `MASK_X, `PAT_BYTE_UX)) k = store_exec_pkg::OP_BYTE_UX;
    else if (isMatch(w, `MASK_X, `PAT_BYTE_X)) k = store_exec_pkg::OP_BYTE_X;
    else if (isMatch(w, `MASK_X, `PAT_DW_COND)) k = store_exec_pkg::OP_DW_COND;
    else if (isMatch(w, `MASK_X, `PAT_DW_UX)) k = store_exec_pkg::OP_DW_UX;
    else if (isMatch(w, `MASK_X, `PAT_DW_X)) k = store_exec_pkg::OP_DW_X;
    else if (isMatch(w, `MASK_DS, `PAT_DW)) k = store_exec_pkg::OP_DW;
    else if (isMatch(w, `MASK_DS, `PAT_DW_U)) k = store_exec_pkg::OP_DW_U;
    else if (isMatch(w, `MASK_D, `PAT_FD)) k = store_exec_pkg::OP_FD;
    else if (isMatch(w, `MASK_D, `PAT_FD_U)) k = store_exec_pkg::OP_FD_U;
    return k;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0]         opWord_q [0:`OPER_WORDS-1];
  logic                dpWrite_q;
  logic [5:0]          dpIdx_q;
  logic                sumOvf_q;
  logic                resvValid_q;
  logic [63:0]         resvAddr_q;
  logic [3:0]          cr0_q;
  logic                illegal_q;
  logic                badForm_q;
  logic                align_q;
  logic                performed_q;
  logic [63:0]         ea_q;
  logic [31:0]         hrdata_q;
  logic                hreadyout_q;
  logic                memWrite_q;
  logic [63:0]         memAddr_q;
  logic [63:0]         memData_q;
  logic [1:0]          memSize_q;

  // ****************************************
  // Bus decode
  // ****************************************
  // Address phase is taken when the bus is ready and the transfer is active
  wire                 addrPhase = hsel && htrans[1] && hready;
  wire  [5:0]          aIdx      = haddr[7:2];
  wire                 aMapped   = (haddr[31:8] == 24'h00_0000) && (aIdx <= `IDX_EA_HI);
  wire                 dpMapped  = dpWrite_q;
  wire                 aOper     = (aIdx >= `IDX_OPER_FIRST) && (aIdx <= `IDX_OPER_LAST);
  wire  [3:0]          aOperIdx  = 4'(aIdx - `IDX_OPER_FIRST);
  wire                 dpOper    = (dpIdx_q >= `IDX_OPER_FIRST) && (dpIdx_q <= `IDX_OPER_LAST);
  wire  [3:0]          dpOperIdx = 4'(dpIdx_q - `IDX_OPER_FIRST);
  wire                 execFire  = dpMapped && (dpIdx_q == `IDX_INSN);
  wire                 resvCmd   = dpMapped && (dpIdx_q == `IDX_RESV_CMD) && hwdata[0];
  wire                 ovfWrite  = dpMapped && (dpIdx_q == `IDX_SUM_OVF);

  // Operand words as 64-bit values, low word first
  wire  [63:0]         baseVal   = {opWord_q[1], opWord_q[0]};
  wire  [63:0]         indexVal  = {opWord_q[3], opWord_q[2]};
  wire  [63:0]         srcVal    = {opWord_q[5], opWord_q[4]};
  wire  [63:0]         fprVal    = {opWord_q[7], opWord_q[6]};
  wire  [63:0]         resvReq   = {opWord_q[9], opWord_q[8]};

  // ****************************************
  // Instruction decode
  // ****************************************
  // Instruction word is the data phase of the INSN write
  wire  [31:0]         insn      = hwdata;
  store_exec_pkg::op_t opKind;
  assign opKind = decodeOp(insn);
  wire                 raZero    = (insn[20:16] == 5'd0);
  wire                 isByte    = (opKind == store_exec_pkg::OP_BYTE_UX) || (opKind == store_exec_pkg::OP_BYTE_X);
  wire                 isFloat   = (opKind == store_exec_pkg::OP_FD) || (opKind == store_exec_pkg::OP_FD_U);
  wire                 isCond    = (opKind == store_exec_pkg::OP_DW_COND);
  wire                 isDsForm  = (opKind == store_exec_pkg::OP_DW) || (opKind == store_exec_pkg::OP_DW_U);
  wire                 isUpdate  = (opKind == store_exec_pkg::OP_BYTE_UX) || (opKind == store_exec_pkg::OP_DW_U)
                                || (opKind == store_exec_pkg::OP_DW_UX) || (opKind == store_exec_pkg::OP_FD_U);
  wire                 isDwInt   = !isByte && !isFloat && (opKind != store_exec_pkg::OP_NONE);

  // ****************************************
  // Effective address
  // ****************************************
  // sign-extended displacements
  wire  [63:0]         dExt      = {{48{insn[15]}}, insn[15:0]};
  wire  [63:0]         dsExt     = {{48{insn[15]}}, insn[15:2], 2'b00};
  // update forms use the base value itself
  wire  [63:0]         baseSel   = (isUpdate || !raZero) ? baseVal : `RST_ADDR;
  // word displacement for DS forms, plain one for float, index otherwise
  wire  [63:0]         offsetSel = isDsForm ? dsExt : (isFloat ? dExt : indexVal);
  // address formed before the reservation is looked at
  wire  [63:0]         eaRaw     = baseSel + offsetSel;
  // A 32-bit implementation keeps the upper half of the address clear
  wire  [63:0]         ea        = IMPL_64 ? eaRaw : {32'h0000_0000, eaRaw[31:0]};

  // ****************************************
  // Legality and reservation outcome
  // ****************************************
  // doubleword integer kinds refused without 64-bit support
  wire                 illegal   = (opKind == store_exec_pkg::OP_NONE) || (isDwInt && !IMPL_64);
  // zero base field makes an update form invalid
  wire                 badForm   = isUpdate && raZero;
  // conditional store demands an eight-byte aligned address
  wire                 misAlign  = isCond && (ea[2:0] != 3'b000);
  wire                 condRun   = isCond && !illegal && !misAlign;
  // Reservation granule is one aligned doubleword
  wire                 resvHit   = resvValid_q && (resvAddr_q[63:3] == ea[63:3]);
  wire                 snoopHit  = snoopValid && resvValid_q && (snoopAddr[63:3] == resvAddr_q[63:3]);
  // conditional store writes only when the reservation matches; a miss skips it
  wire                 doStore   = execFire && !illegal && !badForm && !misAlign && (!isCond || resvHit);
  // Invalid update form skips the write-back too
  wire                 doWback   = execFire && isUpdate && !illegal && !badForm;
  // byte forms carry only the low byte
  wire  [63:0]         storeData = isFloat ? fprVal : (isByte ? {56'h0, srcVal[7:0]} : srcVal);

  // ****************************************
  // Read mux
  // ****************************************
  // Status word, field zero in bits 11:8
  wire  [31:0]         statusWord = {20'h0, cr0_q, 3'h0, resvValid_q, performed_q, align_q, badForm_q, illegal_q};
  wire  [31:0]         readWord  = !aMapped ? `RST_WORD
                                 : aOper ? opWord_q[aOperIdx]
                                 : (aIdx == `IDX_CTRL) ? {31'h0, IMPL_64}
                                 : (aIdx == `IDX_SUM_OVF) ? {31'h0, sumOvf_q}
                                 : (aIdx == `IDX_STATUS) ? statusWord
                                 : (aIdx == `IDX_EA_LO) ? ea_q[31:0]
                                 : (aIdx == `IDX_EA_HI) ? ea_q[63:32]
                                 : `RST_WORD;

  // ****************************************
  // Bus slave
  // ****************************************
  // Read data captured in the address phase so it stands through the data phase
  // Ready stays low in reset, so no transfer is taken too early
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dpWrite_q   <= 1'b0;
      dpIdx_q     <= 6'h00;
      hrdata_q    <= `RST_WORD;
      hreadyout_q <= 1'b0;
    end else begin
      dpWrite_q   <= addrPhase && hwrite && aMapped;
      dpIdx_q     <= aIdx;
      hrdata_q    <= (addrPhase && !hwrite) ? readWord : `RST_WORD;
      hreadyout_q <= 1'b1;
    end
  end

  // ****************************************
  // Operand words
  // ****************************************
  // base words take the address back on update forms
  // Write-back and a bus write never share an edge
  for (genvar i = 0; i < `OPER_WORDS; i++) begin : g_oper
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        opWord_q[i] <= `RST_WORD;
      end else if (doWback && (i < 2)) begin
        opWord_q[i] <= (i == 0) ? ea[31:0] : ea[63:32];
      end else if (dpOper && dpMapped && (dpOperIdx == 4'(i))) begin
        opWord_q[i] <= hwdata;
      end
    end
  end

  // Sum overflow copy, written by software
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sumOvf_q <= 1'b0;
    end else if (ovfWrite) begin
      sumOvf_q <= hwdata[0];
    end
  end

  // ****************************************
  // Reservation
  // ****************************************
  // A new reservation outranks a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resvValid_q <= 1'b0;
      resvAddr_q  <= `RST_ADDR;
    end else if (resvCmd) begin
      resvValid_q <= 1'b1;
      resvAddr_q  <= resvReq;
    end else if ((execFire && condRun) || snoopHit) begin
      // a legal, aligned conditional store clears it, hit or miss
      resvValid_q <= 1'b0;
    end
  end

  // ****************************************
  // Condition field and status
  // ****************************************
  // field zero reflects the conditional outcome
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cr0_q <= 4'h0;
    end else if (execFire && condRun) begin
      cr0_q <= {2'b00, resvHit, sumOvf_q};
    end
  end

  // Outcome of the last executed instruction
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      illegal_q   <= 1'b0;
      badForm_q   <= 1'b0;
      align_q     <= 1'b0;
      performed_q <= 1'b0;
      ea_q        <= `RST_ADDR;
    end else if (execFire) begin
      illegal_q   <= illegal;
      badForm_q   <= badForm;
      align_q     <= misAlign && !illegal;
      performed_q <= doStore;
      ea_q        <= ea;
    end
  end

  // ****************************************
  // Memory port
  // ****************************************
  // Address and data hold until the next store
  // matched conditional store writes the doubleword
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      memWrite_q <= 1'b0;
      memAddr_q  <= `RST_ADDR;
      memData_q  <= `RST_ADDR;
      memSize_q  <= `SIZE_BYTE;
    end else begin
      memWrite_q <= doStore;
      if (doStore) begin
        memAddr_q <= ea;
        memData_q <= storeData;
        memSize_q <= isByte ? `SIZE_BYTE : `SIZE_DWORD;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output straight from its flop, except hresp tied low
  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign memWrite  = memWrite_q;
  assign memAddr   = memAddr_q;
  assign memData   = memData_q;
  assign memSize   = memSize_q;
  assign resvHeld  = resvValid_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Store form and reservation checks
  a_byte_low_only: assert property (execFire && isByte && doStore |=>
    memData_q[63:8] == 56'h0 && memSize_q == `SIZE_BYTE) else $error("byte store data wrong");
  a_update_wback: assert property (doWback |=> baseVal == $past(ea))
    else $error("base not written back");
  a_bad_form_quiet: assert property (execFire && badForm |=> !memWrite_q && badForm_q)
    else $error("invalid form stored");
  a_dw_illegal_32: assert property (execFire && isDwInt && !IMPL_64 |=> illegal_q && !memWrite_q)
    else $error("doubleword op accepted in 32-bit mode");
  a_cond_hit_store: assert property (execFire && condRun && resvHit |=> memWrite_q && cr0_q[`CR0_EQUAL])
    else $error("matched conditional store missing");
  a_no_resv_write: assert property (execFire && isCond && !resvValid_q |=> !memWrite_q)
    else $error("write without reservation");
  a_cr0_layout: assert property (execFire && condRun |=>
    cr0_q[3:2] == 2'b00 && cr0_q[`CR0_SUM_OVF] == $past(sumOvf_q)) else $error("field zero wrong");
  a_align_fault: assert property (execFire && misAlign && !illegal |=> align_q && !memWrite_q)
    else $error("misaligned conditional store not caught");
  a_cond_clears: assert property (execFire && condRun |=> !resvValid_q)
    else $error("reservation kept after conditional store");
  a_snoop_clears: assert property (snoopHit && !resvCmd |=> !resvValid_q)
    else $error("foreign store left reservation");
  a_cr0_only_cond: assert property (execFire && !condRun |=> $stable(cr0_q))
    else $error("field zero changed by other store");

  // Reservation and store data checks
  a_miss_clears: assert property (execFire && condRun && resvValid_q && !resvHit |=>
    !resvValid_q && !memWrite_q) else $error("reservation kept after missed conditional store");
  a_hit_data: assert property (execFire && condRun && resvHit |=> memData_q == $past(srcVal))
    else $error("conditional store data wrong");
  a_float_data: assert property (execFire && isFloat && doStore |=> memData_q == $past(fprVal))
    else $error("float store data wrong");
  a_resv_new: assert property (resvCmd |=> resvValid_q && resvAddr_q == $past(resvReq))
    else $error("reservation not replaced");

  // Main scenarios
  c_cond_success: cover property (execFire && condRun && resvHit ##1 memWrite_q);
  c_misaligned:   cover property (execFire && misAlign && !illegal);
  c_cond_no_resv: cover property (execFire && condRun && !resvValid_q);
  c_snoop_hit:    cover property (snoopHit);
  c_update_store: cover property (doWback && doStore);

endmodule // store_insn_exec_reservation

// ---- tb/mem_partner.sv ----
// Purpose: Memory side model that records stores and reports foreign stores
// Assumes: Stores arrive as one-cycle memWrite pulses on clk_sys
// Notes:   Snoop address carries junk whenever snoopValid is low
module mem_partner (
  input  wire logic        clk_sys,
  input  wire logic        memWrite,
  input  wire logic [63:0] memAddr,
  input  wire logic [63:0] memData,
  input  wire logic [1:0]  memSize,
  output logic             snoopValid,
  output logic      [63:0] snoopAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Store log and snoop driver
  // ****************************************
  int          wrCount = 0;
  logic [63:0] lastAddr;
  logic [63:0] lastData;
  logic [1:0]  lastSize;

  // Idle snoop: nothing flagged at time zero
  initial begin
    snoopValid = 1'b0;
    snoopAddr  = 64'hFFFF_FFFF_FFFF_FFFF;
  end

  // Log each issued store, sampled like a real memory port
  always @(posedge clk_sys) begin
    if (memWrite === 1'b1) begin
      wrCount++;
      lastAddr = memAddr;
      lastData = memData;
      lastSize = memSize;
    end
  end

  // foreign store report
  // One cycle only; address inverted after so a stale match cannot linger
  task automatic foreign(input logic [63:0] a);
    @(posedge clk_sys);
    snoopValid <= 1'b1;
    snoopAddr  <= a;
    @(posedge clk_sys);
    snoopValid <= 1'b0;
    snoopAddr  <= ~a;
  endtask
endmodule // mem_partner

// ---- tb/tb_store_insn_exec_reservation.sv ----
// Purpose: Self-checking bench for the store executor and its reservation
// Assumes: Zero-wait slave; results visible at the data phase edge of the INSN write
// Notes:   A 32-bit instance runs alongside to see doubleword stores refused
`include "store_exec_cfg.svh"
module tb_store_insn_exec_reservation;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] BASE = 64'h0000_0001_0000_1000;
  localparam logic [63:0] IDX  = 64'h0000_0000_0000_0238;
  localparam logic [63:0] SRC  = 64'h1122_3344_5566_7788;
  localparam logic [63:0] FPR  = 64'hCAFE_0000_BEEF_0001;
  localparam logic [63:0] EAX  = BASE + IDX;
  logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, hrdata32, rdA, rdB;
  logic [1:0]  htrans = '0, memSize;
  logic        hreadyout, hresp, memWrite, resvHeld, snoopValid, memWrite32;
  logic [63:0] memAddr, memData, snoopAddr;
  int          failures = 0, cmp_count = 0, wr32 = 0;

  // Clock, and a store counter for the 32-bit instance
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (memWrite32 === 1'b1) wr32++;

  // Single slave, so its hreadyout is the bus hready
  store_insn_exec_reservation uut (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .memWrite, .memAddr, .memData, .memSize, .resvHeld,
    .snoopValid, .snoopAddr);
  store_insn_exec_reservation #(.IMPL_64(1'b0)) uut32 (.clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata(hrdata32), .hreadyout(), .hresp(), .memWrite(memWrite32),
    .memAddr(), .memData(), .memSize(), .resvHeld(), .snoopValid, .snoopAddr);
  mem_partner mem (.clk_sys, .memWrite, .memAddr, .memData, .memSize, .snoopValid, .snoopAddr);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One AHB-Lite single transfer; ready and read data taken at rising edges
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rdA = hrdata;
    rdB = hrdata32;
  endtask

  task automatic wr64(input logic [31:0] a, input logic [63:0] v);
    xfer(a, v[31:0], 1'b1);
    xfer(a + 32'h4, v[63:32], 1'b1);
  endtask

  // Load-and-reserve, then let the edge land before anyone looks
  task automatic resv(input logic [63:0] a);
    wr64(32'h0000_0028, a);
    xfer(32'h0000_0034, 32'h0000_0001, 1'b1);
    @(negedge clk_sys);
  endtask

  function automatic logic [31:0] mk(input logic [31:0] pat, input logic [4:0] ra, input logic [15:0] lo);
    return pat | {6'h0, 5'h01, ra, lo};
  endfunction

  // Execute one store; base reloaded first since update forms overwrite it
  task automatic st(input logic [31:0] ins, input logic perf, input logic [63:0] ea, input logic [63:0] dat,
                    input logic [1:0] sz, input logic [63:0] baseExp, input logic [2:0] stat, input logic [3:0] cr);
    int          c0;
    logic [63:0] v;
    c0 = mem.wrCount;
    wr64(32'h0000_0008, BASE);
    xfer(32'h0000_0004, ins, 1'b1);
    repeat (2) @(posedge clk_sys);
    chk(64'(mem.wrCount - c0), 64'(perf), "store count");
    if (perf) begin
      chk(mem.lastAddr, ea, "address");
      chk(mem.lastData, dat, "data");
      chk(64'(mem.lastSize), 64'(sz), "size");
    end
    xfer(32'h0000_0008, 32'h0, 1'b0);
    v[31:0] = rdA;
    xfer(32'h0000_000C, 32'h0, 1'b0);
    v[63:32] = rdA;
    chk(v, baseExp, "base");
    xfer(32'h0000_0038, 32'h0, 1'b0);
    chk({52'h0, rdA[11:8], 5'h0, rdA[2:0]}, {52'h0, cr, 5'h0, stat}, "status");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk(64'(resvHeld), 64'h0, "resv at reset");
    xfer(32'h0000_0000, 32'h0, 1'b0);
    chk(64'(rdA[0]), 64'h1, "ctrl 64");
    chk(64'(rdB[0]), 64'h0, "ctrl 32");
    xfer(32'h0000_0080, 32'h0, 1'b0);
    chk(64'({rdA, hresp}), 64'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_plain;
    wr64(32'h0000_0010, IDX);
    wr64(32'h0000_0018, SRC);
    wr64(32'h0000_0020, FPR);
    st(mk(`PAT_BYTE_UX, 5'h03, 16'h2000), 1'b1, EAX, 64'h88, 2'h0, EAX, 3'h0, 4'h0);
    st(mk(`PAT_BYTE_X, 5'h00, 16'h2000), 1'b1, IDX, 64'h88, 2'h0, BASE, 3'h0, 4'h0);
    st(mk(`PAT_DW, 5'h03, 16'hFFF8), 1'b1, BASE - 64'h8, SRC, 2'h3, BASE, 3'h0, 4'h0);
    st(mk(`PAT_DW, 5'h00, 16'h0010), 1'b1, 64'h10, SRC, 2'h3, BASE, 3'h0, 4'h0);
    st(mk(`PAT_DW_U, 5'h03, 16'h0010), 1'b1, BASE + 64'h10, SRC, 2'h3, BASE + 64'h10, 3'h0, 4'h0);
    st(mk(`PAT_DW_UX, 5'h03, 16'h2000), 1'b1, EAX, SRC, 2'h3, EAX, 3'h0, 4'h0);
    st(mk(`PAT_DW_X, 5'h00, 16'h2000), 1'b1, IDX, SRC, 2'h3, BASE, 3'h0, 4'h0);
    st(mk(`PAT_FD, 5'h03, 16'h8000), 1'b1, BASE - 64'h8000, FPR, 2'h3, BASE, 3'h0, 4'h0);
    st(mk(`PAT_FD_U, 5'h03, 16'h0100), 1'b1, BASE + 64'h100, FPR, 2'h3, BASE + 64'h100, 3'h0, 4'h0);
    st(mk(`PAT_DW_UX, 5'h00, 16'h2000), 1'b0, 64'h0, 64'h0, 2'h0, BASE, 3'h2, 4'h0);
    $display("test plain stores done");
  endtask

  task automatic t_cond;
    logic [31:0] c;
    c = mk(`PAT_DW_COND, 5'h03, 16'h2000);
    st(c, 1'b0, 64'h0, 64'h0, 2'h0, BASE, 3'h0, 4'h0);
    xfer(32'h0000_0030, 32'h0000_0001, 1'b1);
    resv(EAX);
    chk(64'(resvHeld), 64'h1, "reserve");
    st(c, 1'b1, EAX, SRC, 2'h3, BASE, 3'h0, 4'h3);
    chk(64'(resvHeld), 64'h0, "hit clears");
    st(mk(`PAT_DW, 5'h03, 16'h0000), 1'b1, BASE, SRC, 2'h3, BASE, 3'h0, 4'h3);
    resv(EAX);
    resv(64'h40);
    st(c, 1'b0, 64'h0, 64'h0, 2'h0, BASE, 3'h0, 4'h1);
    chk(64'(resvHeld), 64'h0, "miss clears");
    resv(64'h40);
    resv(EAX);
    st(c, 1'b1, EAX, SRC, 2'h3, BASE, 3'h0, 4'h3);
    resv(EAX);
    mem.foreign(64'h40);
    @(negedge clk_sys);
    chk(64'(resvHeld), 64'h1, "other addr");
    mem.foreign(EAX + 64'h4);
    @(negedge clk_sys);
    chk(64'(resvHeld), 64'h0, "snoop clears");
    st(c, 1'b0, 64'h0, 64'h0, 2'h0, BASE, 3'h0, 4'h1);
    resv(EAX);
    wr64(32'h0000_0010, IDX + 64'h4);
    st(c, 1'b0, 64'h0, 64'h0, 2'h0, BASE, 3'h4, 4'h1);
    chk(64'(resvHeld), 64'h1, "misaligned");
    wr64(32'h0000_0010, IDX);
    $display("test conditional done");
  endtask

  task automatic t_impl32;
    int c;
    c = wr32;
    xfer(32'h0000_0004, mk(`PAT_DW, 5'h03, 16'h0000), 1'b1);
    repeat (2) @(posedge clk_sys);
    xfer(32'h0000_0038, 32'h0, 1'b0);
    chk(64'(rdB[0]), 64'h1, "32-bit illegal");
    chk(64'(wr32 - c), 64'h0, "32-bit no store");
    xfer(32'h0000_0004, mk(`PAT_FD, 5'h03, 16'h0000), 1'b1);
    repeat (2) @(posedge clk_sys);
    xfer(32'h0000_0038, 32'h0, 1'b0);
    chk(64'({rdA[0], rdB[0]}), 64'h0, "float legal");
    chk(64'(wr32 - c), 64'h1, "32-bit float store");
    $display("test 32-bit done");
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset for 4 cycles, then the scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_plain;
    t_cond;
    t_impl32;
    summarize;
  end

  // Watchdog: run needs a few hundred cycles, so 50 us means a hang
  initial begin
    #50_000;
    failures++;
    $display("FAIL %0t watchdog expired", $time);
    summarize;
  end
endmodule // tb_store_insn_exec_reservation
